/* hw/dpsb_pkg.sv */
/*
 * shared constants of the burst-counter port: data and address widths,
 * byte lanes, register offsets, field positions and bus responses.
 * assumes a single 20 MHz clock domain and an AXI4-Lite register bus.
 */
package dpsb_pkg;

   // ---------------------------------------------------------------
   // array shape
   // ---------------------------------------------------------------
   localparam int DATA_W       = 36;
   localparam int ADDR_W_SMALL = 14;
   localparam int ADDR_W_LARGE = 15;
   localparam int LANES        = 4;

   // ---------------------------------------------------------------
   // register map
   // ---------------------------------------------------------------
   localparam int         AXI_ADDR_W    = 8;
   localparam logic [7:0] CTRL_OFFSET   = 8'h00;
   localparam logic [7:0] STATUS_OFFSET = 8'h04;
   localparam int         CTRL_ENA_BIT  = 0;
   localparam logic       CTRL_ENA_RST  = 1'b1;
   localparam int         STAT_LIVE_BIT = 16;
   localparam int         STAT_MODE_BIT = 17;
   localparam logic [1:0] RESP_OKAY     = 2'h0;
   localparam logic [1:0] RESP_SLVERR   = 2'h2;

   typedef enum logic [1:0] {
      DEC_CTRL,
      DEC_STATUS,
      DEC_NONE
   } dpsb_dec_e;

endpackage

/* hw/dpsb_mem.sv */
/*
 * single-port word array with per-lane write enables and a registered
 * read word. assumes one clock and a synchronous active-low reset that
 * only clears the read register, never the array.
 */
`timescale 1ns/1ps
module dpsb_mem #(
   parameter int DW    = 36,
   parameter int AW    = 14,
   parameter int LANES = 4
) (
   input  wire logic             clk,
   input  wire logic             rst_n,
   input  wire logic             wr_en,
   input  wire logic [LANES-1:0] lane_wr,
   input  wire logic             rd_en,
   input  wire logic [AW-1:0]    addr,
   input  wire logic [DW-1:0]    wdata,
   output logic      [DW-1:0]    rdata
);

   localparam int LW = DW / LANES;

   logic [DW-1:0] mem [2**AW];

   // ---------------------------------------------------------------
   // array access
   // ---------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (wr_en) begin
         for (int i = 0; i < LANES; i++) begin
            if (lane_wr[i]) begin
               mem[addr][i*LW +: LW] <= wdata[i*LW +: LW];
            end
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         rdata <= '0;
      end else if (rd_en) begin
         rdata <= mem[addr];
      end
   end

endmodule

/* hw/dpsb_port.sv */
/*
 * one synchronous port of a dual-ported word array: burst address
 * counter, read/write selection, byte lanes, output enable, flow-through
 * or pipelined read data, chip-enable power-down, AXI4-Lite registers.
 * assumes all port pins are synchronous to aclk and a bus master that
 * keeps to AXI4-Lite handshakes.
 */
// Function
// - counter loads address only when strobe and count advance both low.
// - counter clear low makes the address strobe ignored.
// - count advance low with strobe high increments the burst counter on every edge.
// - counter clear low makes count advance ignored.
// - counter clear low sets the burst counter to zero.
// - clear wins over strobe and count advance in the same cycle.
// - output enable low lets the port drive data; high never drives.
// - read_write_n low writes the data bus at the selected address.
// - output_mode_select low gives flow-through, output register bypassed.
// - output_mode_select high gives pipelined, read data registered.
// - each asserted byte lane reads or writes only its own byte.
// - needs a free-running clock; an access-only clock changes when data are driven.
// - burst counter wraps to the first location past the last.
// - chip enable high powers the port down.
// - pipelined outputs need one cycle chip enable low to wake.
// - words and data bus are 36 bits wide.
`timescale 1ns/1ps
module dpsb_port #(
   parameter int DW    = dpsb_pkg::DATA_W,
   parameter int AW    = dpsb_pkg::ADDR_W_SMALL,
   parameter int LANES = dpsb_pkg::LANES
) (
   input  wire logic                        aclk,
   input  wire logic                        aresetn,
   input  wire logic [AW-1:0]               addr,
   input  wire logic                        addr_strobe_n,
   input  wire logic                        count_advance_n,
   input  wire logic                        counter_clear_n,
   input  wire logic                        chip_enable_n,
   input  wire logic                        read_write_n,
   input  wire logic                        out_enable_n,
   input  wire logic                        output_mode_select,
   input  wire logic [LANES-1:0]            byte_lane_select_n,
   input  wire logic [DW-1:0]               data_i,
   output logic      [DW-1:0]               data_o,
   output logic      [LANES-1:0]            data_oe,
   input  wire logic [dpsb_pkg::AXI_ADDR_W-1:0] s_axi_awaddr,
   input  wire logic                        s_axi_awvalid,
   output logic                             s_axi_awready,
   input  wire logic [31:0]                 s_axi_wdata,
   input  wire logic [3:0]                  s_axi_wstrb,
   input  wire logic                        s_axi_wvalid,
   output logic                             s_axi_wready,
   output logic      [1:0]                  s_axi_bresp,
   output logic                             s_axi_bvalid,
   input  wire logic                        s_axi_bready,
   input  wire logic [dpsb_pkg::AXI_ADDR_W-1:0] s_axi_araddr,
   input  wire logic                        s_axi_arvalid,
   output logic                             s_axi_arready,
   output logic      [31:0]                 s_axi_rdata,
   output logic      [1:0]                  s_axi_rresp,
   output logic                             s_axi_rvalid,
   input  wire logic                        s_axi_rready
);

   // ---------------------------------------------------------------
   // elaboration checks
   // ---------------------------------------------------------------
   if (DW % LANES != 0 || AW < 1 || AW > 16) begin : g_bad_params
      $error("dpsb_port: lanes must divide width, address 1 to 16 bits");
   end

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [AW-1:0]    count;
      logic             ft_valid;
      logic [LANES-1:0] ft_lanes;
      logic             pl_valid;
      logic [LANES-1:0] pl_lanes;
      logic [DW-1:0]    pl_data;
      logic             port_enable;
      logic             aw_got;
      logic [7:0]       aw_addr;
      logic             w_got;
      logic [31:0]      wdata;
      logic [3:0]       wstrb;
      logic             bvalid;
      logic [1:0]       bresp;
      logic             rvalid;
      logic [1:0]       rresp;
      logic [31:0]      rdata;
   } dpsb_state_s;

   dpsb_state_s q;
   dpsb_state_s next_q;

   logic          active;
   logic          clear;
   logic          load;
   logic          incr;
   logic          ext_only;
   logic [AW-1:0] acc_addr;
   logic          mem_wr;
   logic          mem_rd;
   logic [DW-1:0] mem_rdata;
   logic          out_live;

   function automatic dpsb_pkg::dpsb_dec_e reg_decode(input logic [7:0] a);
      if (a == dpsb_pkg::CTRL_OFFSET) begin
         return dpsb_pkg::DEC_CTRL;
      end else if (a == dpsb_pkg::STATUS_OFFSET) begin
         return dpsb_pkg::DEC_STATUS;
      end
      return dpsb_pkg::DEC_NONE;
   endfunction

   // ---------------------------------------------------------------
   // access qualification
   // ---------------------------------------------------------------
   // every action but output enable and mode select is taken at a clock edge from sampled pins; the edge after a read
   // clears the flow-through valid and loads the pipelined stage, so a gated clock changes when data are driven
   assign active   = !chip_enable_n && q.port_enable;
   assign clear    = !counter_clear_n;
   assign load     = !clear && !addr_strobe_n && !count_advance_n;
   assign incr     = !clear && addr_strobe_n && !count_advance_n;
   assign ext_only = !clear && !addr_strobe_n && count_advance_n;
   assign acc_addr = ext_only ? addr : next_q.count;
   assign mem_wr   = active && !read_write_n;
   assign mem_rd   = active && read_write_n;
   assign out_live = output_mode_select ? q.pl_valid : q.ft_valid;

   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   always_comb begin
      next_q = q;
      // clear is tested first, so strobe and advance cannot block it
      if (clear) begin
         next_q.count = '0;
      end else if (load) begin
         next_q.count = addr;
      end else if (incr) begin
         next_q.count = q.count + 1'b1;
      end
      next_q.ft_valid = mem_rd;
      next_q.ft_lanes = ~byte_lane_select_n;
      // wake-up cycle: the pipelined stage needs a prior enabled read
      next_q.pl_valid = q.ft_valid && active;
      next_q.pl_lanes = q.ft_lanes;
      next_q.pl_data  = mem_rdata;

      if (s_axi_awvalid && s_axi_awready) begin
         next_q.aw_got  = 1'b1;
         next_q.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         next_q.w_got = 1'b1;
         next_q.wdata = s_axi_wdata;
         next_q.wstrb = s_axi_wstrb;
      end
      if (q.bvalid && s_axi_bready) begin
         next_q.bvalid = 1'b0;
      end
      if (q.aw_got && q.w_got && !q.bvalid) begin
         next_q.aw_got = 1'b0;
         next_q.w_got  = 1'b0;
         next_q.bvalid = 1'b1;
         next_q.bresp  = dpsb_pkg::RESP_OKAY;
         unique case (reg_decode(q.aw_addr))
            dpsb_pkg::DEC_CTRL: begin
               if (q.wstrb[0]) begin
                  next_q.port_enable = q.wdata[dpsb_pkg::CTRL_ENA_BIT];
               end
            end
            dpsb_pkg::DEC_STATUS: begin
            end
            dpsb_pkg::DEC_NONE: begin
               next_q.bresp = dpsb_pkg::RESP_SLVERR;
            end
            default: begin
               next_q.bresp = dpsb_pkg::RESP_SLVERR;
            end
         endcase
      end

      if (q.rvalid && s_axi_rready) begin
         next_q.rvalid = 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
         next_q.rvalid = 1'b1;
         next_q.rresp  = dpsb_pkg::RESP_OKAY;
         next_q.rdata  = '0;
         unique case (reg_decode(s_axi_araddr))
            dpsb_pkg::DEC_CTRL: begin
               next_q.rdata[dpsb_pkg::CTRL_ENA_BIT] = q.port_enable;
            end
            dpsb_pkg::DEC_STATUS: begin
               next_q.rdata = {{(32-AW){1'b0}}, q.count};
               next_q.rdata[dpsb_pkg::STAT_LIVE_BIT] = out_live;
               next_q.rdata[dpsb_pkg::STAT_MODE_BIT] = output_mode_select;
            end
            dpsb_pkg::DEC_NONE: begin
               next_q.rresp = dpsb_pkg::RESP_SLVERR;
            end
            default: begin
               next_q.rresp = dpsb_pkg::RESP_SLVERR;
            end
         endcase
      end

      if (!aresetn) begin
         next_q             = '0;
         next_q.port_enable = dpsb_pkg::CTRL_ENA_RST;
      end
   end

   always_ff @(posedge aclk) begin
      q <= next_q;
   end

   // ---------------------------------------------------------------
   // word array
   // ---------------------------------------------------------------
   dpsb_mem #(
      .DW    (DW),
      .AW    (AW),
      .LANES (LANES)
   ) u_mem (
      .clk     (aclk),
      .rst_n   (aresetn),
      .wr_en   (mem_wr),
      .lane_wr (~byte_lane_select_n),
      .rd_en   (mem_rd),
      .addr    (acc_addr),
      .wdata   (data_i),
      .rdata   (mem_rdata)
   );

   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   // flow-through reads the array register directly, pipelined adds
   // one more stage; both are flops, the mux only picks one
   assign data_o  = output_mode_select ? q.pl_data : mem_rdata;
   assign data_oe = {LANES{!out_enable_n && out_live}}
                    & (output_mode_select ? q.pl_lanes : q.ft_lanes);

   assign s_axi_awready = !q.aw_got && !q.bvalid;
   assign s_axi_wready  = !q.w_got && !q.bvalid;
   assign s_axi_bvalid  = q.bvalid;
   assign s_axi_bresp   = q.bresp;
   assign s_axi_arready = !q.rvalid;
   assign s_axi_rvalid  = q.rvalid;
   assign s_axi_rresp   = q.rresp;
   assign s_axi_rdata   = q.rdata;

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sequence s_sleep;
      chip_enable_n;
   endsequence

   sequence s_wake;
      s_sleep ##1 !chip_enable_n;
   endsequence

   property p_clear_wins;
      !counter_clear_n |=> q.count == '0;
   endproperty
   a_clear_wins: assert property (p_clear_wins)
      else $error("counter not zero after clear");

   property p_load;
      (counter_clear_n && !addr_strobe_n && !count_advance_n)
         |=> q.count == $past(addr);
   endproperty
   a_load: assert property (p_load)
      else $error("counter did not load the address");

   property p_strobe_only;
      (counter_clear_n && !addr_strobe_n && count_advance_n)
         |=> $stable(q.count);
   endproperty
   a_strobe_only: assert property (p_strobe_only)
      else $error("counter moved on strobe alone");

   property p_incr;
      (counter_clear_n && addr_strobe_n && !count_advance_n
       && q.count != '1) |=> q.count == $past(q.count) + 1'b1;
   endproperty
   a_incr: assert property (p_incr)
      else $error("counter did not advance by one");

   property p_wrap;
      (counter_clear_n && addr_strobe_n && !count_advance_n
       && q.count == '1) |=> q.count == '0;
   endproperty
   a_wrap: assert property (p_wrap)
      else $error("counter did not wrap to zero");

   property p_oe_off;
      out_enable_n |-> data_oe == '0;
   endproperty
   a_oe_off: assert property (p_oe_off)
      else $error("data driven with output enable high");

   property p_sleep;
      s_sleep |=> !q.ft_valid ##0 !q.pl_valid;
   endproperty
   a_sleep: assert property (p_sleep)
      else $error("outputs live after chip enable high");

   property p_wake;
      s_wake |-> !q.pl_valid ##1 !q.pl_valid;
   endproperty
   a_wake: assert property (p_wake)
      else $error("pipelined output woke without a lead cycle");

   property p_pipe_lag;
      q.ft_valid |=> q.pl_data == $past(mem_rdata);
   endproperty
   a_pipe_lag: assert property (p_pipe_lag)
      else $error("pipelined data not one cycle behind");

   property p_flow;
      !output_mode_select |-> data_o == mem_rdata;
   endproperty
   a_flow: assert property (p_flow)
      else $error("flow-through data not bypassing the stage");

   property p_write_no_drive;
      (active && !read_write_n) |=> !q.ft_valid;
   endproperty
   a_write_no_drive: assert property (p_write_no_drive)
      else $error("write cycle marked as read data");

endmodule

/* tb/dpsb_host.sv */
/*
 * host model on the pin side of one port: drives address, controls,
 * byte lanes and write data by non-blocking assignment.
 * assumes every task is called at a rising edge of aclk.
 */
`timescale 1ns/1ps
module dpsb_host #(
   parameter int AW = 14
) (
   input  wire logic          aclk,
   output logic [AW-1:0]      addr,
   output logic               addr_strobe_n,
   output logic               count_advance_n,
   output logic               counter_clear_n,
   output logic               chip_enable_n,
   output logic               read_write_n,
   output logic               out_enable_n,
   output logic               output_mode_select,
   output logic [3:0]         byte_lane_select_n,
   output logic [35:0]        data_i
);
   // ---------------------------------------------------------------
   // pin drivers
   // ---------------------------------------------------------------
   initial begin
      {chip_enable_n, out_enable_n, addr_strobe_n} = 3'b011;
      {count_advance_n, counter_clear_n, read_write_n} = 3'b111;
      output_mode_select = 1'b0;
      byte_lane_select_n = 4'hF;
      addr = '0;
      data_i = 36'h0;
   end
   // c = {ce_n, oe_n, strobe_n, advance_n, clear_n, rw_n}
   task automatic op(input logic [AW-1:0] a, input logic [5:0] c,
                     input logic [3:0] ln, input logic [35:0] d);
      addr <= a;
      {chip_enable_n, out_enable_n} <= c[5:4];
      addr_strobe_n <= c[3];
      {count_advance_n, counter_clear_n} <= c[2:1];
      read_write_n <= c[0];
      byte_lane_select_n <= ln;
      // not writing: lines carry junk, never the last word
      data_i <= c[0] ? ~data_i : d;
      @(posedge aclk);
   endtask
   task automatic idle();
      // output enable stays as the access left it: read data show next cycle
      {addr_strobe_n, count_advance_n} <= 2'b11;
      {counter_clear_n, read_write_n} <= 2'b11;
      byte_lane_select_n <= 4'hF;
      data_i <= ~data_i;
      addr <= ~addr;
   endtask
   task automatic mode(input logic m);
      output_mode_select <= m;
   endtask
endmodule

/* tb/dual_port_sram_port_burst_counter_tb_top.sv */
/*
 * self-checking bench of the burst-counter port: pins through the host
 * model, registers through AXI4-Lite tasks.
 * assumes a free-running aclk shared by host model and port.
 */
`timescale 1ns/1ps
module dual_port_sram_port_burst_counter_tb_top;
   localparam int AW = dpsb_pkg::ADDR_W_SMALL;
   localparam logic [35:0] WA = 36'hA5A5A5A5A, WB = 36'h123456789;
   localparam logic [35:0] WC = 36'hFEDCBA987, WD = 36'h0F0F0F0F0;
   localparam logic [35:0] WE = 36'h3C3C3C3C3, WF = 36'h555555555;
   localparam logic [5:0]  RD_S = 6'h07, WR_S = 6'h16, WR_L = 6'h12;
   localparam logic [5:0]  WR_A = 6'h1A, WR_C = 6'h10, RD_OE = 6'h17;
   localparam logic [5:0]  WR_CE = 6'h36, RD_CE = 6'h27;
   localparam logic [1:0]  OK = dpsb_pkg::RESP_OKAY;
   localparam logic [1:0]  ERR = dpsb_pkg::RESP_SLVERR;
   localparam logic [7:0]  ST = dpsb_pkg::STATUS_OFFSET;
   localparam logic [7:0]  CT = dpsb_pkg::CTRL_OFFSET;
   // live bit left out: its timing is the design's own choice
   localparam logic [31:0] SM = 32'hFFFEFFFF;
   logic          aclk, aresetn, addr_strobe_n, count_advance_n;
   logic          counter_clear_n, chip_enable_n, read_write_n;
   logic          out_enable_n, output_mode_select;
   logic [AW-1:0] addr;
   logic [3:0]    byte_lane_select_n, data_oe, s_axi_wstrb;
   logic [35:0]   data_i, data_o;
   logic [7:0]    s_axi_awaddr, s_axi_araddr;
   logic [31:0]   s_axi_wdata, s_axi_rdata;
   logic [1:0]    s_axi_bresp, s_axi_rresp;
   logic          s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic          s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic          s_axi_rvalid, s_axi_rready;
   int            err_count, total_checks;

   dpsb_port #(.AW(AW)) DUT (.aclk, .aresetn, .addr, .addr_strobe_n,
      .count_advance_n, .counter_clear_n, .chip_enable_n, .read_write_n,
      .out_enable_n, .output_mode_select, .byte_lane_select_n, .data_i,
      .data_o, .data_oe, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
      .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready);
   dpsb_host #(.AW(AW)) h (.aclk, .addr, .addr_strobe_n, .count_advance_n,
      .counter_clear_n, .chip_enable_n, .read_write_n, .out_enable_n,
      .output_mode_select, .byte_lane_select_n, .data_i);

   // ---------------------------------------------------------------
   // compare and access tasks
   // ---------------------------------------------------------------
   task automatic miss(input logic [35:0] g, e);
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
   endtask
   task automatic chk_w(input logic [35:0] g, e);
      total_checks++;
      if (g !== e) miss(g, e);
   endtask
   task automatic chk_r(input logic [31:0] g, e);
      total_checks++;
      if (g !== e) miss({4'h0, g}, {4'h0, e});
   endtask
   task automatic chk_s(input logic [3:0] g, e);
      total_checks++;
      if (g !== e) miss({32'h0, g}, {32'h0, e});
   endtask
   task automatic wr(input logic [AW-1:0] a, input logic [5:0] c,
                     input logic [3:0] ln, input logic [35:0] d);
      h.op(a, c, ln, d);
      h.idle();
      @(posedge aclk);
   endtask
   // pipelined reads answer one edge later and show no drive before
   task automatic rd(input logic [AW-1:0] a, input logic [5:0] c,
                     input logic [3:0] ln, input logic [35:0] ed,
                     input logic [3:0] eo);
      h.op(a, c, ln, 36'h0);
      h.idle();
      if (output_mode_select) begin
         #1 chk_s(data_oe, 4'h0);
         @(posedge aclk);
      end
      #1 chk_w(data_o, ed);
      chk_s(data_oe, eo);
      @(posedge aclk);
   endtask
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                         input logic [1:0] er);
      int n;
      logic aw_hit, w_hit, b_hit;
      logic [1:0] resp;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
      n = 0;
      // handshakes are judged on settled values before the edge; reading
      // at the edge itself races the slave's own register update
      do begin
         #1;
         aw_hit = s_axi_awready && s_axi_awvalid;
         w_hit = s_axi_wready && s_axi_wvalid;
         b_hit = (s_axi_bvalid === 1'b1);
         resp = s_axi_bresp;
         @(posedge aclk);
         n++;
         if (aw_hit) s_axi_awvalid <= 1'b0;
         if (w_hit) s_axi_wvalid <= 1'b0;
      end while (!b_hit && n < 40);
      s_axi_bready <= 1'b0;
      if (n >= 40) err_count++;
      chk_s({2'b0, resp}, {2'b0, er});
      @(posedge aclk);
   endtask
   task automatic axi_rd(input logic [7:0] a, input logic [31:0] m, e,
                         input logic [1:0] er);
      int n;
      logic ar_hit, r_hit;
      logic [31:0] data;
      logic [1:0] resp;
      s_axi_araddr <= a;
      {s_axi_arvalid, s_axi_rready} <= 2'b11;
      n = 0;
      do begin
         #1;
         ar_hit = s_axi_arready && s_axi_arvalid;
         r_hit = (s_axi_rvalid === 1'b1);
         data = s_axi_rdata;
         resp = s_axi_rresp;
         @(posedge aclk);
         n++;
         if (ar_hit) s_axi_arvalid <= 1'b0;
      end while (!r_hit && n < 40);
      s_axi_rready <= 1'b0;
      if (n >= 40) err_count++;
      chk_r(data & m, e);
      chk_s({2'b0, resp}, {2'b0, er});
      @(posedge aclk);
   endtask
   task automatic print_verdict();
      $display("checks=%0d errors=%0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   // ---------------------------------------------------------------
   // clock, watchdog and tests
   // ---------------------------------------------------------------
   initial begin
      aclk = 1'b0;
      forever #25 aclk = ~aclk;
   end
   initial begin
      repeat (3000) @(posedge aclk);
      err_count++;
      print_verdict();
   end
   initial begin
      {err_count, total_checks} = '0;
      aresetn = 1'b0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
      {s_axi_arvalid, s_axi_rready} = '0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      s_axi_wstrb = 4'hF;
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      axi_rd(CT, '1, 32'h1, OK);
      axi_rd(ST, SM, 32'h0, OK);
      axi_rd(8'h08, '1, 32'h0, ERR);
      axi_wr(8'h08, 32'h1, ERR);
      axi_wr(ST, 32'hFFFF, OK);
      h.op(14'h0003, WR_L, 4'h0, WA);
      h.op(14'h2000, WR_A, 4'h0, WB);
      wr(14'h2000, WR_A, 4'h0, WC);
      axi_rd(ST, SM, 32'h5, OK);
      rd(14'h0004, RD_S, 4'h0, WB, 4'hF);
      axi_rd(ST, SM, 32'h5, OK);
      rd(14'h0003, RD_S, 4'h0, WA, 4'hF);
      rd(14'h0005, RD_S, 4'h0, WC, 4'hF);
      wr(14'h0004, WR_S, 4'hE, WD);
      rd(14'h0004, RD_S, 4'h0, {WB[35:9], WD[8:0]}, 4'hF);
      rd(14'h0004, RD_S, 4'hD, {WB[35:9], WD[8:0]}, 4'h2);
      rd(14'h0004, RD_OE, 4'h0, {WB[35:9], WD[8:0]}, 4'h0);
      wr(14'h1234, WR_C, 4'h0, WE);
      axi_rd(ST, SM, 32'h0, OK);
      rd(14'h0000, RD_S, 4'h0, WE, 4'hF);
      h.op(14'h3FFF, WR_L, 4'h0, WF);
      wr(14'h0100, WR_A, 4'h0, WA);
      axi_rd(ST, SM, 32'h0, OK);
      rd(14'h3FFF, RD_S, 4'h0, WF, 4'hF);
      rd(14'h0000, RD_S, 4'h0, WA, 4'hF);
      wr(14'h0003, WR_CE, 4'h0, WE);
      rd(14'h0003, RD_CE, 4'h0, WA, 4'h0);
      rd(14'h0003, RD_S, 4'h0, WA, 4'hF);
      axi_wr(CT, 32'h0, OK);
      wr(14'h0005, WR_S, 4'h0, WF);
      axi_wr(CT, 32'h1, OK);
      rd(14'h0005, RD_S, 4'h0, WC, 4'hF);
      h.mode(1'b1);
      rd(14'h0004, RD_S, 4'h0, {WB[35:9], WD[8:0]}, 4'hF);
      wr(14'h0003, WR_CE, 4'h0, WE);
      rd(14'h0003, RD_S, 4'h0, WA, 4'hF);
      axi_rd(ST, SM, 32'h20000, OK);
      h.mode(1'b0);
      rd(14'h0003, RD_S, 4'h0, WA, 4'hF);
      print_verdict();
   end
endmodule
